// ---- include/sut_pkg.sv ----
// Constants and types shared by the supervision timer design.
// Assumes a single clock, the oscillator, and a synchronous power-on reset.
//
// Function
// RULE1 - Twenty-three bit counter on the oscillator clock
// RULE2 - Power-on reset forces count to zero
// RULE3 - Count advances by one each clock
// RULE4 - Overflow records event and resets microcontroller
// RULE5 - Two to the twenty-two periods allowed
// RULE6 - Writing one at 45H clears count
// RULE7 - Software clears before the count overflows
// RULE8 - Idle mode keeps counting and resetting
// RULE9 - Stop mode halts counter, keeps count
// RULE10 - Software clears before entering Stop mode
// RULE11 - Count restarts from zero after overflow
package sut_pkg;

    // ----------------------------------------------------------------
    // Counter geometry and timing
    // ----------------------------------------------------------------
    localparam int SUT_CNT_WIDTH = 23;
    localparam int SUT_PERIOD_EXP = 22;
    // Oscillator periods allowed between clears
    localparam int SUT_PERIOD_CYCLES = 2 ** SUT_PERIOD_EXP;
    // Clock cycles the microcontroller reset output stays high
    localparam int SUT_RESET_PULSE_CYCLES = 4;
    localparam logic [SUT_CNT_WIDTH-1:0] SUT_CNT_RESET = 23'h000000;

    // ----------------------------------------------------------------
    // Derivative register map
    // ----------------------------------------------------------------
    localparam int SUT_REG_ADDR_WIDTH = 8;
    localparam int SUT_REG_DATA_WIDTH = 8;
    localparam logic [SUT_REG_ADDR_WIDTH-1:0] SUT_ADDR_CLEAR_STROBE = 8'h45;
    localparam int SUT_CLEAR_BIT = 0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SUT_RUN,
        SUT_EXPIRED,
        SUT_RESETTING
    } sut_state_t;

    typedef struct packed {
        logic wrEn;
        logic [SUT_REG_ADDR_WIDTH-1:0] addr;
        logic [SUT_REG_DATA_WIDTH-1:0] data;
    } sut_reg_wr_t;

    typedef struct packed {
        logic idle;
        logic oscRun;
    } sut_mode_t;

endpackage

// ---- rtl/sut_reset_pulse.sv ----
// Stretches a one-cycle trigger into a fixed-length reset pulse.
// Assumes the trigger is a registered one-cycle pulse.
`timescale 1ns/100ps

module sut_reset_pulse
    import sut_pkg::*;
#(
    parameter int LEN = SUT_RESET_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Trigger in, pulse out
    input wire logic trigger,
    output logic pulseOut
);

    localparam int CW = $clog2(LEN + 1);

    generate
        if (LEN < 1) begin : g_bad_len
            $error("reset pulse length must be at least one cycle");
        end
    endgenerate

    typedef struct packed {
        logic active;
        logic [CW-1:0] remain;
    } sut_pulse_state_t;

    sut_pulse_state_t state_q;
    sut_pulse_state_t state_d;

    always_comb begin
        state_d = state_q;
        if (trigger) begin
            state_d.active = 1'b1;
            state_d.remain = CW'(LEN - 1);
        end else if (state_q.active) begin
            if (state_q.remain == '0) begin
                state_d.active = 1'b0;
            end else begin
                state_d.remain = state_q.remain - CW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign pulseOut = state_q.active;

endmodule // sut_reset_pulse

// ---- rtl/sut_supervision_timer.sv ----
// Supervision timer: a free-running counter that resets the
// microcontroller unless software clears it in time.
// Assumes derivative register writes arrive synchronous to clk and that
// the oscillator-running flag is low only in Stop mode.
`timescale 1ns/100ps

module sut_supervision_timer
    import sut_pkg::*;
#(
    parameter int CNT_WIDTH = SUT_CNT_WIDTH,
    parameter int PERIOD_CYCLES = SUT_PERIOD_CYCLES,
    parameter int RESET_PULSE = SUT_RESET_PULSE_CYCLES
) (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic srst,
    // Derivative register write port
    input wire logic regWrEn,
    input wire logic [SUT_REG_ADDR_WIDTH-1:0] regAddr,
    input wire logic [SUT_REG_DATA_WIDTH-1:0] regWrData,
    // Power mode
    input wire logic idleMode,
    input wire logic oscRun,
    // Status and reset outputs
    output logic [CNT_WIDTH-1:0] count,
    output logic clearSeen,
    output logic overflowEvent,
    output logic expiredCause,
    output logic mcuReset
);

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    generate
        if (CNT_WIDTH < 2 || CNT_WIDTH > 31) begin : g_bad_width
            $error("counter width out of range");
        end
        if (PERIOD_CYCLES < 2 || PERIOD_CYCLES > 2 ** (CNT_WIDTH - 1))
        begin : g_bad_period
            $error("period must fit below the counter top bit");
        end
        if (RESET_PULSE < 1) begin : g_bad_pulse
            $error("reset pulse must last at least one cycle");
        end
    endgenerate

    localparam logic [CNT_WIDTH-1:0] LAST_COUNT =
        CNT_WIDTH'(PERIOD_CYCLES - 1);

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    function automatic logic is_clear_write(input sut_reg_wr_t wr);
        is_clear_write = wr.wrEn && (wr.addr == SUT_ADDR_CLEAR_STROBE)
            && wr.data[SUT_CLEAR_BIT];
    endfunction

    function automatic logic counting(input sut_mode_t mode);
        // Idle keeps the oscillator alive, so only Stop freezes the count
        counting = mode.oscRun;
    endfunction

    sut_reg_wr_t regWr;
    sut_mode_t mode;

    assign regWr = '{wrEn: regWrEn, addr: regAddr, data: regWrData};
    assign mode = '{idle: idleMode, oscRun: oscRun};

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        sut_state_t fsm;
        logic [CNT_WIDTH-1:0] cnt;
        logic clearSeen;
        logic ovf;
        logic cause;
    } sut_top_state_t;

    sut_top_state_t state_q;
    sut_top_state_t state_d;
    logic pulseActive;
    logic clearReq;

    assign clearReq = is_clear_write(regWr);

    always_comb begin
        state_d = state_q;
        state_d.ovf = 1'b0;
        state_d.clearSeen = clearReq;
        case (state_q.fsm)
            SUT_RUN: begin
                if (clearReq) begin
                    // RULE6 clear on write
                    state_d.cnt = '0;
                end else if (counting(mode)) begin
                    // RULE5 limit check
                    if (state_q.cnt == LAST_COUNT) begin
                        // RULE4 overflow event
                        state_d.cnt = '0;
                        state_d.ovf = 1'b1;
                        state_d.cause = 1'b1;
                        state_d.fsm = SUT_EXPIRED;
                    end else begin
                        // RULE3 increment by one
                        // RULE8 idle keeps counting
                        state_d.cnt = state_q.cnt + CNT_WIDTH'(1);
                    end
                end
                // RULE9 Stop holds the count when oscRun is low
            end
            SUT_EXPIRED: begin
                state_d.cnt = '0;
                state_d.fsm = SUT_RESETTING;
            end
            SUT_RESETTING: begin
                // RULE11 restart from zero
                state_d.cnt = '0;
                if (!pulseActive) begin
                    state_d.fsm = SUT_RUN;
                end
            end
            default: begin
                state_d.cnt = '0;
                state_d.fsm = SUT_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            // RULE2 zero at power-on
            state_q <= '{fsm: SUT_RUN, cnt: CNT_WIDTH'(SUT_CNT_RESET),
                clearSeen: 1'b0, ovf: 1'b0, cause: 1'b0};
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // Microcontroller reset pulse
    // ----------------------------------------------------------------
    // RULE4 drive chip reset
    sut_reset_pulse #(
        .LEN(RESET_PULSE)
    ) u_pulse (
        .clk(clk),
        .srst(srst),
        .trigger(state_q.ovf),
        .pulseOut(pulseActive)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // RULE1 counter value out
    assign count = state_q.cnt;
    assign clearSeen = state_q.clearSeen;
    assign overflowEvent = state_q.ovf;
    assign expiredCause = state_q.cause;
    assign mcuReset = pulseActive;

endmodule // sut_supervision_timer

// ---- verif/sut_supervision_timer_assertions.sv ----
// Port checker for the supervision timer.
// Assumes it is bound to sut_supervision_timer with the same parameters.
`timescale 1ns/100ps

module sut_supervision_timer_assertions
    import sut_pkg::*;
#(
    parameter int CNT_WIDTH = SUT_CNT_WIDTH,
    parameter int PERIOD_CYCLES = SUT_PERIOD_CYCLES,
    parameter int RESET_PULSE = SUT_RESET_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register write and mode
    input wire logic regWrEn,
    input wire logic [SUT_REG_ADDR_WIDTH-1:0] regAddr,
    input wire logic [SUT_REG_DATA_WIDTH-1:0] regWrData,
    input wire logic idleMode,
    input wire logic oscRun,
    // Outputs
    input wire logic [CNT_WIDTH-1:0] count,
    input wire logic clearSeen,
    input wire logic overflowEvent,
    input wire logic expiredCause,
    input wire logic mcuReset
);
    logic wrClr;
    logic busy;
    logic pulseEnd_q;
    assign wrClr = regWrEn && regAddr == SUT_ADDR_CLEAR_STROBE && regWrData[0];
    // The cycle after the pulse falls still holds the count at zero
    always_ff @(posedge clk) begin
        if (srst) begin
            pulseEnd_q <= 1'b0;
        end else begin
            pulseEnd_q <= mcuReset;
        end
    end
    // Overflow cycle, reset pulse and its tail hold the count
    assign busy = mcuReset || overflowEvent || pulseEnd_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    por_clear_a: assert property (disable iff (1'b0)
        srst |=> count == '0 && !mcuReset && !expiredCause)
        else $error("power-on reset did not clear");
    cnt_step_a: assert property (
        oscRun && !wrClr && !busy && count < PERIOD_CYCLES - 1
        |=> count == $past(count) + 1'b1)
        else $error("count did not step by one");
    stop_hold_a: assert property (
        !oscRun && !wrClr && !busy |=> $stable(count))
        else $error("count moved with oscillator stopped");
    clr_zero_a: assert property (
        wrClr && !busy |=> count == '0 && clearSeen)
        else $error("clear write not taken");
    ovf_fire_a: assert property (
        oscRun && !wrClr && !busy && count == PERIOD_CYCLES - 1
        |=> overflowEvent && count == '0)
        else $error("overflow not raised");
    cnt_bound_a: assert property (count < PERIOD_CYCLES)
        else $error("count ran past its period");
    pulse_len_a: assert property (
        overflowEvent |=> mcuReset [*4] ##1 !mcuReset)
        else $error("reset pulse length wrong");
    cnt_restart_a: assert property (
        $fell(mcuReset) |-> count == '0 && expiredCause)
        else $error("count not restarted from zero");
    mcu_cause_a: assert property (
        $rose(mcuReset) |-> $past(overflowEvent))
        else $error("reset without overflow");
endmodule // sut_supervision_timer_assertions

bind sut_supervision_timer sut_supervision_timer_assertions #(
    .CNT_WIDTH(CNT_WIDTH), .PERIOD_CYCLES(PERIOD_CYCLES),
    .RESET_PULSE(RESET_PULSE)
) sva (.clk(clk), .srst(srst), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .idleMode(idleMode), .oscRun(oscRun),
    .count(count), .clearSeen(clearSeen), .overflowEvent(overflowEvent),
    .expiredCause(expiredCause), .mcuReset(mcuReset));

// ---- verif/sut_supervision_timer_tb_top.sv ----
// Self-checking bench for the supervision timer.
// Assumes the port checker is bound in; period shortened to 16 cycles.
`timescale 1ns/100ps

module sut_supervision_timer_tb_top;
    import sut_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic regWrEn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic idleMode = 1'b0;
    logic oscRun = 1'b1;
    logic [22:0] count;
    logic clearSeen, overflowEvent, expiredCause, mcuReset;
    int error_cnt = 0;
    int checks = 0;
    always #25 clk = ~clk;
    sut_supervision_timer #(.PERIOD_CYCLES(16), .RESET_PULSE(4)) dut (
        .clk(clk), .srst(srst), .regWrEn(regWrEn), .regAddr(regAddr),
        .regWrData(regWrData), .idleMode(idleMode), .oscRun(oscRun),
        .count(count), .clearSeen(clearSeen),
        .overflowEvent(overflowEvent), .expiredCause(expiredCause),
        .mcuReset(mcuReset));
    // Flags: clearSeen, overflowEvent, expiredCause, mcuReset
    task automatic chk(input logic [3:0] f, input logic [22:0] c);
        logic [26:0] got;
        got = {clearSeen, overflowEvent, expiredCause, mcuReset, count};
        checks++;
        if (got !== {f, c}) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, {f, c});
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        cyc(1);
    endtask
    task automatic t_count;
        for (int k = 1; k <= 5; k++) begin
            cyc(1);
            chk(4'h0, 23'(k));
        end
    endtask
    task automatic t_clear;
        wr(8'h44, 8'h01);
        wr(8'h45, 8'hFE);
        chk(4'h0, 23'h7);
        wr(8'h45, 8'h01);
        chk(4'h8, 23'h0);
        wr(8'h45, 8'hFF);
        regWrEn = 1'b0;
        chk(4'h8, 23'h0);
        cyc(1);
        chk(4'h0, 23'h1);
    endtask
    task automatic t_ovf;
        idleMode = 1'b1;
        cyc(14);
        chk(4'h0, 23'hF);
        cyc(1);
        chk(4'h6, 23'h0);
        for (int k = 0; k < 4; k++) begin
            cyc(1);
            chk(4'h3, 23'h0);
        end
        cyc(1);
        chk(4'h2, 23'h0);
        cyc(1);
        chk(4'h2, 23'h0);
        cyc(1);
        chk(4'h2, 23'h1);
        idleMode = 1'b0;
    endtask
    task automatic t_stop;
        wr(8'h45, 8'h01);
        regWrEn = 1'b0;
        chk(4'hA, 23'h0);
        cyc(2);
        oscRun = 1'b0;
        chk(4'h2, 23'h2);
        cyc(3);
        chk(4'h2, 23'h2);
        oscRun = 1'b1;
        cyc(1);
        chk(4'h2, 23'h3);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        cyc(2);
        chk(4'h0, 23'h0);
        srst = 1'b0;
        t_count();
        t_clear();
        t_ovf();
        t_stop();
        srst = 1'b1;
        cyc(1);
        chk(4'h0, 23'h0);
        srst = 1'b0;
        final_report();
    end
    initial begin
        #200000;
        error_cnt++;
        final_report();
    end
endmodule // sut_supervision_timer_tb_top
